/* File: design/icr_pkg.sv */
// Shared constants for the interrupt control register block.
package icr_pkg;
  // Clock rate and acceptance widths of the filtered remote pin.
  localparam int ICR_CLK_KHZ   = 50000;
  localparam int ICR_W1_US     = 200;
  localparam int ICR_W2_US     = 400;
  localparam int ICR_W3_MS     = 2;
  localparam int ICR_W4_MS     = 4;
  localparam int ICR_W1_CYC    = (ICR_W1_US * ICR_CLK_KHZ + 999) / 1000;
  localparam int ICR_W2_CYC    = (ICR_W2_US * ICR_CLK_KHZ + 999) / 1000;
  localparam int ICR_W3_CYC    = ICR_W3_MS * ICR_CLK_KHZ;
  localparam int ICR_W4_CYC    = ICR_W4_MS * ICR_CLK_KHZ;
  // Basic timer 0 base tick of 5 ms and the dividers derived from it.
  localparam int ICR_TICK_MS   = 5;
  localparam int ICR_TICK_CYC  = ICR_TICK_MS * ICR_CLK_KHZ;
  localparam int ICR_DIV_50HZ  = 4;
  localparam int ICR_DIV_10HZ  = 20;
  localparam int ICR_MAINS_D5  = 5;
  localparam int ICR_MAINS_D6  = 6;
  localparam int ICR_CNT_W     = 18;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] ICR_IDX_TMRCLK = 8'h09;
  localparam logic [7:0] ICR_IDX_LEVEL  = 8'h0f;
  localparam logic [7:0] ICR_IDX_WIDTH  = 8'h15;
  localparam logic [7:0] ICR_IDX_EDGE   = 8'h1f;
  localparam logic [7:0] ICR_IDX_ENABLE = 8'h2f;
  localparam logic [7:0] ICR_IDX_REQ    = 8'h3f;
  localparam logic [7:0] ICR_IDX_STATUS = 8'h40;
  localparam logic [7:0] ICR_IDX_MASK   = 8'h41;
  // Bit positions inside the 4-bit registers.
  localparam int ICR_BIT_SERIAL = 3;
  localparam int ICR_BIT_VSYNC  = 2;
  localparam int ICR_BIT_TIMER  = 1;
  localparam int ICR_BIT_REMOTE = 0;
  // Width select codes.
  localparam logic [2:0] ICR_WSEL_EDGE = 3'h0;
  localparam logic [2:0] ICR_WSEL_200  = 3'h1;
  localparam logic [2:0] ICR_WSEL_400  = 3'h2;
  localparam logic [2:0] ICR_WSEL_2MS  = 3'h3;
  localparam logic [2:0] ICR_WSEL_4MS  = 3'h4;
  // Timer interrupt pulse select codes.
  localparam logic [2:0] ICR_TSEL_200A = 3'h0;
  localparam logic [2:0] ICR_TSEL_10   = 3'h1;
  localparam logic [2:0] ICR_TSEL_50A  = 3'h2;
  localparam logic [2:0] ICR_TSEL_50B  = 3'h3;
  localparam logic [2:0] ICR_TSEL_200B = 3'h4;
  localparam logic [2:0] ICR_TSEL_EXT5 = 3'h5;
  localparam logic [2:0] ICR_TSEL_200C = 3'h6;
  localparam logic [2:0] ICR_TSEL_EXT6 = 3'h7;
  // Reset values and bus transfer codes.
  localparam logic [3:0] ICR_RST_ZERO  = 4'h0;
  localparam logic [3:0] ICR_EN_SOFT   = 4'hf;
  localparam logic [1:0] ICR_HTRANS_NS = 2'h2;
  localparam logic [2:0] ICR_HSIZE_W   = 3'h2;
endpackage

/* File: design/icr_top.sv */
// Interrupt control registers with pin filter, edge logic and AHB-Lite slave.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - Read-only level register shows vsync, filtered pin.
// - Width code sets minimum accepted remote pulse.
// - Edge register picks rising or falling polarity.
// - Enable bits gate each of four sources onto int_pending.
// - Request flags show pending requests per source.
// - Timer clock field selects timer interrupt rate.
module icr_top
  import icr_pkg::*;
#(
  parameter int W1_CYC   = ICR_W1_CYC,
  parameter int W2_CYC   = ICR_W2_CYC,
  parameter int W3_CYC   = ICR_W3_CYC,
  parameter int W4_CYC   = ICR_W4_CYC,
  parameter int TICK_CYC = ICR_TICK_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        vsync_pin,
  input  wire logic        remote_pin,
  input  wire logic        mains_pin,
  input  wire logic        serial0_event,
  input  wire logic [3:0]  int_ack,
  input  wire logic        soft_reset,
  output logic             int_pending,
  output logic             irq
);

  // Counters are sized for the documented widths; larger W4 or tick counts are refused.
  if (W1_CYC < 1 || W2_CYC < 1 || W3_CYC < 1 || W4_CYC < 1 || TICK_CYC < 1 ||
      W4_CYC >= 2**ICR_CNT_W || TICK_CYC >= 2**ICR_CNT_W) begin : g_chk
    $error("icr_top: count parameter out of range");
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [2:0]           sync1_q;
  logic [2:0]           sync2_q;
  logic                 vs_s;
  logic                 rmt_s;
  logic                 mains_s;
  logic                 vs_prev_q;
  logic                 flt_q;
  logic                 flt_prev_q;
  logic                 mains_prev_q;
  logic [ICR_CNT_W-1:0] flt_cnt_q;
  logic [ICR_CNT_W-1:0] width_cyc;
  logic [ICR_CNT_W-1:0] tick_cnt_q;
  logic                 tick5;
  logic [4:0]           div_cnt_q;
  logic [2:0]           mains_cnt_q;
  logic                 mains_tick;
  logic                 tmr_evt;
  logic [3:0]           evt;
  logic [3:0]           tmrclk_q;
  logic [3:0]           width_q;
  logic [3:0]           edge_q;
  logic [3:0]           en_q;
  logic [3:0]           req_q;
  logic [3:0]           status_q;
  logic [3:0]           mask_q;
  logic                 accept;
  logic                 wr_pend_q;
  logic [7:0]           wr_idx_q;
  logic                 wr_en;
  logic [3:0]           rd_val;
  logic [7:0]           acc_idx;

  // Pins are asynchronous, so each passes two flip-flops first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {mains_pin, remote_pin, vsync_pin};
      sync2_q <= sync1_q;
    end
  end

  assign vs_s    = sync2_q[0];
  assign rmt_s   = sync2_q[1];
  assign mains_s = sync2_q[2];

  // Acceptance width in cycles; unused codes behave as edge only.
  // width code decode
  always_comb begin
    unique case (width_q[2:0])
      ICR_WSEL_200: width_cyc = ICR_CNT_W'(W1_CYC);
      ICR_WSEL_400: width_cyc = ICR_CNT_W'(W2_CYC);
      ICR_WSEL_2MS: width_cyc = ICR_CNT_W'(W3_CYC);
      ICR_WSEL_4MS: width_cyc = ICR_CNT_W'(W4_CYC);
      default:      width_cyc = ICR_CNT_W'(1);
    endcase
  end

  // The filtered level follows the pin only after it has held for the width.
  // A pulse that ends early restarts the count, so glitches never reach flt_q.
  // pulse width filter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flt_q     <= 1'b0;
      flt_cnt_q <= '0;
    end else if (rmt_s == flt_q) begin
      flt_cnt_q <= '0;
    end else if (flt_cnt_q + ICR_CNT_W'(1) >= width_cyc) begin
      flt_q     <= rmt_s;
      flt_cnt_q <= '0;
    end else begin
      flt_cnt_q <= flt_cnt_q + ICR_CNT_W'(1);
    end
  end

  // Previous values for the edge detectors.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vs_prev_q    <= 1'b0;
      flt_prev_q   <= 1'b0;
      mains_prev_q <= 1'b0;
    end else begin
      vs_prev_q    <= vs_s;
      flt_prev_q   <= flt_q;
      mains_prev_q <= mains_s;
    end
  end

  // Base 5 ms tick for basic timer 0.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= '0;
    end else if (tick5) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + ICR_CNT_W'(1);
    end
  end

  assign tick5 = (tick_cnt_q == ICR_CNT_W'(TICK_CYC - 1));
  // Shared divider of base ticks; 50 Hz and 10 Hz both fall on its phases.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= 5'h0;
    end else if (tick5) begin
      if (div_cnt_q == 5'(ICR_DIV_10HZ - 1)) begin
        div_cnt_q <= 5'h0;
      end else begin
        div_cnt_q <= div_cnt_q + 5'h1;
      end
    end
  end

  // Mains pulses are counted on rising edges and divided by five or six.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mains_cnt_q <= 3'h0;
    end else if (mains_s && !mains_prev_q) begin
      if (mains_tick) begin
        mains_cnt_q <= 3'h0;
      end else begin
        mains_cnt_q <= mains_cnt_q + 3'h1;
      end
    end
  end

  assign mains_tick = (tmrclk_q[2:0] == ICR_TSEL_EXT6) ?
                      (mains_cnt_q == 3'(ICR_MAINS_D6 - 1)) :
                      (mains_cnt_q == 3'(ICR_MAINS_D5 - 1));
  always_comb begin
    unique case (tmrclk_q[2:0])
      ICR_TSEL_10:   tmr_evt = tick5 && (div_cnt_q == 5'h0);
      ICR_TSEL_50A,
      ICR_TSEL_50B:  tmr_evt = tick5 && (div_cnt_q[1:0] == 2'(ICR_DIV_50HZ - 4));
      ICR_TSEL_EXT5,
      ICR_TSEL_EXT6: tmr_evt = mains_s && !mains_prev_q && mains_tick;
      default:       tmr_evt = tick5;
    endcase
  end

  // Source events; polarity bit 0 means the new level is high.
  // edge polarity select
  always_comb begin
    evt = 4'h0;
    evt[ICR_BIT_SERIAL] = serial0_event;
    evt[ICR_BIT_VSYNC]  = (vs_s != vs_prev_q) && (vs_s == !edge_q[ICR_BIT_VSYNC]);
    evt[ICR_BIT_TIMER]  = tmr_evt;
    evt[ICR_BIT_REMOTE] = (flt_q != flt_prev_q) && (flt_q == !edge_q[ICR_BIT_REMOTE]);
  end

  // Request flags clear when service starts; a new event wins over the clear.
  // request flag update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= ICR_RST_ZERO;
    end else if (soft_reset) begin
      req_q <= ICR_RST_ZERO;
    end else begin
      req_q <= (req_q & ~int_ack) | evt;
    end
  end

  // Bus slave: zero wait states, so the address phase decides everything.
  assign accept  = hsel && hready && (htrans == ICR_HTRANS_NS) && (hsize == ICR_HSIZE_W);
  assign acc_idx = haddr[9:2];
  assign wr_en   = wr_pend_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h0;
    end else begin
      wr_pend_q <= accept && hwrite;
      wr_idx_q  <= acc_idx;
    end
  end

  // Timer clock select; the zero-cross bit is stored but drives nothing here.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmrclk_q <= ICR_RST_ZERO;
    end else if (wr_en && wr_idx_q == ICR_IDX_TMRCLK) begin
      tmrclk_q <= hwdata[3:0];
    end
  end

  // width register reset and fixed bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      width_q <= ICR_RST_ZERO;
    end else if (soft_reset) begin
      width_q <= ICR_RST_ZERO;
    end else if (wr_en && wr_idx_q == ICR_IDX_WIDTH) begin
      width_q <= {1'b0, hwdata[2:0]};
    end
  end

  // Only the two polarity bits are stored; the others read zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_q <= ICR_RST_ZERO;
    end else if (soft_reset) begin
      edge_q <= ICR_RST_ZERO;
    end else if (wr_en && wr_idx_q == ICR_IDX_EDGE) begin
      edge_q <= hwdata[3:0] & 4'h5;
    end
  end

  // Enables come up off at power-on but all on after a soft reset.
  // enable register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= ICR_RST_ZERO;
    end else if (soft_reset) begin
      en_q <= ICR_EN_SOFT;
    end else if (wr_en && wr_idx_q == ICR_IDX_ENABLE) begin
      en_q <= hwdata[3:0];
    end
  end

  // Sticky status, write one to clear; an event in the same cycle wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= ICR_RST_ZERO;
    end else if (wr_en && wr_idx_q == ICR_IDX_STATUS) begin
      status_q <= (status_q & ~hwdata[3:0]) | evt;
    end else begin
      status_q <= status_q | evt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= ICR_RST_ZERO;
    end else if (wr_en && wr_idx_q == ICR_IDX_MASK) begin
      mask_q <= hwdata[3:0];
    end
  end

  // Read mux; unmapped indices read zero.
  // level readback
  always_comb begin
    unique case (acc_idx)
      ICR_IDX_TMRCLK: rd_val = tmrclk_q;
      ICR_IDX_LEVEL:  rd_val = {1'b0, vs_s, 1'b0, flt_q};
      ICR_IDX_WIDTH:  rd_val = width_q;
      ICR_IDX_EDGE:   rd_val = edge_q;
      ICR_IDX_ENABLE: rd_val = en_q;
      ICR_IDX_REQ:    rd_val = req_q;
      ICR_IDX_STATUS: rd_val = status_q;
      ICR_IDX_MASK:   rd_val = mask_q;
      default:        rd_val = 4'h0;
    endcase
  end

  // Read data is latched at the address phase so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= (accept && !hwrite) ? {28'h0, rd_val} : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // CPU request line and the masked sticky interrupt, both registered.
  // enable gating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_pending <= 1'b0;
      irq         <= 1'b0;
    end else begin
      int_pending <= |(req_q & en_q);
      irq         <= |(status_q & mask_q);
    end
  end

  sequence s_rd_level;
    accept && !hwrite && acc_idx == ICR_IDX_LEVEL;
  endsequence
  sequence s_wr_width;
    accept && hwrite && acc_idx == ICR_IDX_WIDTH && !soft_reset ##1 !soft_reset;
  endsequence
  level_read_a: assert property (
    s_rd_level |=> hrdata == {28'h0, 1'b0, $past(vs_s), 1'b0, $past(flt_q)})
    else $error("level register read mismatch");
  edge_mode_pass_a: assert property (
    width_q[2:0] == ICR_WSEL_EDGE && rmt_s != flt_q |=> flt_q == $past(rmt_s))
    else $error("edge mode did not follow pin");
  filter_hold_a: assert property (
    $changed(flt_q) |-> ($past(flt_cnt_q) + 1) >= $past(width_cyc))
    else $error("filtered level changed before width");
  vsync_edge_a: assert property (
    vs_s && !vs_prev_q && !edge_q[ICR_BIT_VSYNC] && !soft_reset |=> req_q[ICR_BIT_VSYNC])
    else $error("vsync rising edge lost");
  pending_gate_a: assert property (
    |(req_q & en_q) |=> int_pending ##1 (int_pending == $past(|(req_q & en_q))))
    else $error("pending output does not follow enable");
  ack_clear_a: assert property (
    int_ack[ICR_BIT_SERIAL] && !serial0_event |=> !req_q[ICR_BIT_SERIAL])
    else $error("request not cleared by service");
  width_write_a: assert property (
    s_wr_width |=> width_q == {1'b0, $past(hwdata[2:0])})
    else $error("width register write wrong");
  soft_clear_a: assert property (
    soft_reset |=> width_q == 4'h0 && edge_q == 4'h0 && en_q == 4'hf)
    else $error("soft reset values wrong");
  timer_rate_a: assert property (
    tick5 && tmrclk_q[2:0] == ICR_TSEL_200A && !soft_reset |=> req_q[ICR_BIT_TIMER])
    else $error("timer 200 Hz request lost");

endmodule

/* File: verification/icr_pin_model.sv */
// Model of the pins that feed the interrupt block: sync, remote and mains inputs.
`timescale 1ns/10ps
module icr_pin_model (
  input  wire logic clk,
  output logic      vsync_pin,
  output logic      remote_pin,
  output logic      mains_pin
);
  // Pins idle low; mains only moves while an external timer rate is under test.
  initial begin
    vsync_pin  = 1'b0;
    remote_pin = 1'b0;
    mains_pin  = 1'b0;
  end

  // Drive one pin to a level just after a rising edge, so it never moves on a sampling edge.
  task automatic set_pin(input logic which, input logic val);
    @(posedge clk);
    if (which) begin
      remote_pin <= val;
    end else begin
      vsync_pin <= val;
    end
  endtask

  // A high pulse of len cycles; the remote filter judges it by this length.
  task automatic pulse(input logic which, input int len);
    set_pin(which, 1'b1);
    repeat (len - 1) @(posedge clk);
    set_pin(which, 1'b0);
  endtask

  // Mains pulses three cycles high and three low, so each survives synchronisation once.
  task automatic mains_pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      mains_pin <= 1'b1;
      repeat (3) @(posedge clk);
      mains_pin <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the interrupt control register block.
`timescale 1ns/10ps
module testbench;
  import icr_pkg::*;
  localparam int TICK = 50;
  logic        hclk          = 1'b0;
  logic        hresetn       = 1'b0;
  logic        hsel          = 1'b1;
  logic [31:0] haddr         = 32'h0;
  logic [31:0] hwdata        = 32'h0;
  logic [1:0]  htrans        = 2'h0;
  logic        hwrite        = 1'b0;
  logic [2:0]  hsize         = 3'h2;
  logic [3:0]  int_ack       = 4'h0;
  logic        serial0_event = 1'b0;
  logic        soft_reset    = 1'b0;
  logic [31:0] rd;
  wire         hready;
  wire         hresp;
  wire  [31:0] hrdata;
  wire         int_pending;
  wire         irq;
  wire         vsync_pin;
  wire         remote_pin;
  wire         mains_pin;
  int          errors        = 0;
  int          checked       = 0;

  // The clock toggles every 10 ns, a period of 20 ns.
  always #10 hclk = ~hclk;

  // Short widths and tick keep the run brief; expectations use the same figures.
  icr_top #(.W1_CYC(4), .W2_CYC(8), .W3_CYC(12), .W4_CYC(16), .TICK_CYC(TICK)) icr_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .vsync_pin(vsync_pin),
    .remote_pin(remote_pin), .mains_pin(mains_pin), .serial0_event(serial0_event),
    .int_ack(int_ack), .soft_reset(soft_reset), .int_pending(int_pending), .irq(irq));

  icr_pin_model pins_i (.clk(hclk), .vsync_pin(vsync_pin), .remote_pin(remote_pin),
    .mains_pin(mains_pin));

  task automatic final_report;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Wait for hready high at a rising edge; read data is taken at that same edge.
  task automatic wait_ready(output logic [31:0] d);
    int   n;
    logic ok;
    n = 0;
    do begin
      @(posedge hclk);
      ok = (hready === 1'b1);
      d  = hrdata;
      n++;
    end while (!ok && n < 50);
    if (!ok) begin
      errors++;
      final_report();
    end
  endtask

  // One AHB-Lite single word transfer; the byte address is four times the index.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] d);
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= ICR_HTRANS_NS;
    hsize  <= ICR_HSIZE_W;
    wait_ready(d);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(d);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, idx, wd, dummy);
  endtask

  task automatic ack(input logic [3:0] bits);
    int_ack <= bits;
    @(posedge hclk);
    int_ack <= 4'h0;
    @(posedge hclk);
  endtask

  // Reset values, access kinds, fixed zero bits and the soft reset values.
  task automatic t_regs;
    bus(0, ICR_IDX_LEVEL, 0, rd);  check("level rst", 0, rd);
    bus(0, ICR_IDX_WIDTH, 0, rd);  check("width rst", 0, rd);
    bus(0, ICR_IDX_EDGE, 0, rd);   check("edge rst", 0, rd);
    bus(0, ICR_IDX_ENABLE, 0, rd); check("en rst", 0, rd);
    bus(0, ICR_IDX_REQ, 0, rd);    check("req rst", 0, rd & 32'hd);
    bus(0, 8'h30, 0, rd);          check("unmapped", 0, rd);
    check("hresp okay", 0, hresp);
    wr(ICR_IDX_WIDTH, 32'hf); bus(0, ICR_IDX_WIDTH, 0, rd); check("width rw", 7, rd);
    wr(ICR_IDX_EDGE, 32'hf);  bus(0, ICR_IDX_EDGE, 0, rd);  check("edge rw", 5, rd);
    wr(ICR_IDX_ENABLE, 32'hf); bus(0, ICR_IDX_ENABLE, 0, rd); check("en rw", 32'hf, rd);
    wr(ICR_IDX_REQ, 32'hf);   bus(0, ICR_IDX_REQ, 0, rd);   check("req ro", 0, rd & 32'hd);
    wr(ICR_IDX_LEVEL, 32'hf); bus(0, ICR_IDX_LEVEL, 0, rd); check("level ro", 0, rd);
    soft_reset <= 1'b1;
    @(posedge hclk);
    soft_reset <= 1'b0;
    @(posedge hclk);
    bus(0, ICR_IDX_WIDTH, 0, rd);  check("width soft", 0, rd);
    bus(0, ICR_IDX_ENABLE, 0, rd); check("en soft", 32'hf, rd);
    wr(ICR_IDX_ENABLE, 0);
  endtask

  // Pin levels show in the level register after synchronisation.
  task automatic t_level;
    pins_i.set_pin(1'b0, 1'b1);
    pins_i.set_pin(1'b1, 1'b1);
    repeat (6) @(posedge hclk);
    bus(0, ICR_IDX_LEVEL, 0, rd); check("level high", 5, rd);
    pins_i.set_pin(1'b0, 1'b0);
    pins_i.set_pin(1'b1, 1'b0);
    repeat (6) @(posedge hclk);
    bus(0, ICR_IDX_LEVEL, 0, rd); check("level low", 0, rd);
  endtask

  // Width codes 1 to 4: a pulse two cycles short is dropped, one four cycles longer than the width requests.
  task automatic t_remote;
    int w;
    for (int c = 1; c <= 4; c++) begin
      w = 4 * c;
      wr(ICR_IDX_WIDTH, c);
      ack(4'hf);
      pins_i.pulse(1'b1, w - 2);
      repeat (w + 6) @(posedge hclk);
      bus(0, ICR_IDX_REQ, 0, rd); check("remote short", 0, rd & 32'h1);
      pins_i.pulse(1'b1, w + 4);
      // The wait lets the filtered level fall again before the next width is tried.
      repeat (w + 6) @(posedge hclk);
      bus(0, ICR_IDX_REQ, 0, rd); check("remote long", 1, rd & 32'h1);
      bus(0, ICR_IDX_LEVEL, 0, rd); check("remote level", 0, rd & 32'h1);
    end
    wr(ICR_IDX_WIDTH, 0);
  endtask

  // Falling polarity on vsync, and the masked sticky status behind irq.
  task automatic t_vsync_irq;
    wr(ICR_IDX_EDGE, 32'h4);
    ack(4'hf);
    wr(ICR_IDX_STATUS, 32'hf);
    wr(ICR_IDX_MASK, 32'h4);
    pins_i.set_pin(1'b0, 1'b1);
    repeat (6) @(posedge hclk);
    bus(0, ICR_IDX_REQ, 0, rd); check("vsync rise", 0, rd & 32'h4);
    check("irq idle", 0, irq);
    pins_i.set_pin(1'b0, 1'b0);
    repeat (6) @(posedge hclk);
    bus(0, ICR_IDX_REQ, 0, rd); check("vsync fall", 4, rd & 32'h4);
    check("irq set", 1, irq);
    // The register lands at the write's second edge and irq follows one edge later.
    wr(ICR_IDX_MASK, 0);
    repeat (2) @(posedge hclk);
    check("irq masked", 0, irq);
    wr(ICR_IDX_MASK, 32'h4);
    repeat (2) @(posedge hclk);
    check("irq unmasked", 1, irq);
    wr(ICR_IDX_STATUS, 32'h4);
    repeat (2) @(posedge hclk);
    check("irq cleared", 0, irq);
  endtask

  // Serial request is gated by its enable; the timer flag follows the selected tick.
  task automatic t_serial_timer;
    serial0_event <= 1'b1;
    @(posedge hclk);
    serial0_event <= 1'b0;
    repeat (3) @(posedge hclk);
    check("pending off", 0, int_pending);
    bus(0, ICR_IDX_REQ, 0, rd); check("serial req", 8, rd & 32'h8);
    wr(ICR_IDX_ENABLE, 32'h8);
    repeat (2) @(posedge hclk);
    check("pending on", 1, int_pending);
    ack(4'h8);
    bus(0, ICR_IDX_REQ, 0, rd); check("serial ack", 0, rd & 32'h8);
    check("pending cleared", 0, int_pending);
    wr(ICR_IDX_TMRCLK, ICR_TSEL_200A);
    ack(4'h2);
    poll_timer();
    check("timer req", 2, rd & 32'h2);
    t_timer_rate(ICR_TSEL_50A, ICR_DIV_50HZ * TICK - 40);
    t_timer_rate(ICR_TSEL_10, ICR_DIV_10HZ * TICK - 80);
  endtask

  // Read the request register until the timer flag shows, within a bounded number of reads.
  task automatic poll_timer;
    rd = 0;
    for (int n = 0; n < 1000 && rd[1] !== 1'b1; n++) bus(0, ICR_IDX_REQ, 0, rd);
  endtask

  // An internal rate: once a request is served, none follows for lo cycles, then one does.
  task automatic t_timer_rate(input logic [2:0] code, input int lo);
    wr(ICR_IDX_TMRCLK, {29'h0, code});
    ack(4'h2);
    poll_timer();
    check("timer first", 2, rd & 32'h2);
    ack(4'h2);
    repeat (lo) @(posedge hclk);
    bus(0, ICR_IDX_REQ, 0, rd); check("timer quiet", 0, rd & 32'h2);
    poll_timer();
    check("timer again", 2, rd & 32'h2);
  endtask

  // External rates count mains rising edges: every fifth, then every sixth.
  task automatic t_timer_mains;
    wr(ICR_IDX_TMRCLK, {29'h0, ICR_TSEL_EXT5});
    ack(4'h2);
    pins_i.mains_pulses(ICR_MAINS_D5 - 1);
    bus(0, ICR_IDX_REQ, 0, rd); check("mains five early", 0, rd & 32'h2);
    pins_i.mains_pulses(1);
    bus(0, ICR_IDX_REQ, 0, rd); check("mains five", 2, rd & 32'h2);
    wr(ICR_IDX_TMRCLK, {29'h0, ICR_TSEL_EXT6});
    ack(4'h2);
    pins_i.mains_pulses(ICR_MAINS_D6 - 1);
    bus(0, ICR_IDX_REQ, 0, rd); check("mains six early", 0, rd & 32'h2);
    pins_i.mains_pulses(1);
    bus(0, ICR_IDX_REQ, 0, rd); check("mains six", 2, rd & 32'h2);
  endtask

  // Watchdog for the whole run.
  initial begin
    repeat (100000) @(posedge hclk);
    errors++;
    final_report();
  end

  // Reset for five cycles, then the scenarios in turn.
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_level();
    t_remote();
    t_vsync_irq();
    t_serial_timer();
    t_timer_mains();
    final_report();
  end
endmodule
